// [logic/flash_cmd_ctrl.sv]
// Flash command controller: control bits, unlock, self-timed program and
// erase, one-cycle read, interrupt, AXI4-Lite register slave.
// Assumes a flash array that reads combinationally and acts on strobes.
//
// Operation
// [R1] Control bit 6 steers accesses to the program array at 0 and to the configuration/ID area at 1.
// [R2] With the latch-only bit set a write command only loads the latch, otherwise it also programs the row.
// [R3] With the erase bit set a write command erases and hardware clears the erase bit when done.
// [R4] The fault flag is set on an improper start or an early end, and stays 0 on a normal finish.
// [R5] Program and erase happen only while the enable bit is 1.
// [R6] Setting the write command starts a self-timed operation, hardware clears it, software cannot.
// [R7] The latch-only bit has no effect on an erase.
// [R8] Software writes 55h then AAh to the unlock port before setting the write command.
// [R9] Setting the read command fetches the word in one cycle and hardware clears the bit.
// [R10] A write command with the enable bit 0 or without unlock leaves the flash untouched.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_cfg.svh"

module flash_cmd_ctrl #(
  parameter int PROG_TIME_US = `PROG_TIME_US,
  parameter int ERASE_TIME_US = `ERASE_TIME_US,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_space,
  output logic [`FLASH_ADDR_W-1:0] flash_addr,
  output logic [`FLASH_DATA_W-1:0] flash_wdata,
  output logic flash_read,
  output logic flash_latch_load,
  output logic flash_row_program,
  output logic flash_erase,
  output logic flash_abort,
  input wire logic [`FLASH_DATA_W-1:0] flash_rdata,
  output logic irq
);

  localparam logic [`TICK_W-1:0] PROG_TICKS = `TICK_W'(PROG_TIME_US * `TICK_NS / `TICK_NS);
  localparam logic [`TICK_W-1:0] ERASE_TICKS = `TICK_W'(ERASE_TIME_US * `TICK_NS / `TICK_NS);

  flash_ctrl_pkg::ctrl_s s_ff;
  flash_ctrl_pkg::ctrl_s nxt_s;
  logic armed;
  logic tmr_busy;
  logic tmr_done;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  flash_unlock_seq flash_unlock_seq_inst (
    .mclk(mclk),
    .rstn(rstn),
    .key_we(s_ff.key_we),
    .key_byte(s_ff.key_byte),
    .consume(s_ff.consume),
    .armed(armed)
  );

  flash_op_timer #(.TICK_CYCLES(TICK_CYCLES)) flash_op_timer_inst (
    .mclk(mclk),
    .rstn(rstn),
    .start(s_ff.tmr_start),
    .abort(s_ff.tmr_abort),
    .ticks(s_ff.tmr_ticks),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic do_write;
    logic do_read;
    logic wr_req;
    logic [`IRQ_W-1:0] events;
    logic [`IRQ_W-1:0] w1c;
    logic [7:0] wb;
    logic [15:0] m16;
    do_write = 1'b0;
    do_read = 1'b0;
    wr_req = 1'b0;
    events = '0;
    w1c = '0;
    wb = '0;
    m16 = '0;
    nxt_s = s_ff;
    nxt_s.f_read = 1'b0;
    nxt_s.f_latch = 1'b0;
    nxt_s.f_prog = 1'b0;
    nxt_s.f_erase = 1'b0;
    nxt_s.f_abort = 1'b0;
    nxt_s.key_we = 1'b0;
    nxt_s.consume = 1'b0;
    nxt_s.tmr_start = 1'b0;
    nxt_s.tmr_abort = 1'b0;
    // Bus write: address and data taken in either order
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wbus = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
      do_write = 1'b1;
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `RESP_OKAY;
    end
    wb = s_ff.wbus[7:0];
    if (do_write) begin
      case (s_ff.awaddr)
        `OFS_CONTROL: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.space = wb[`CTL_BIT_SPACE];
            nxt_s.latch_only = wb[`CTL_BIT_LATCH];
            nxt_s.erase_sel = wb[`CTL_BIT_ERASE];
            nxt_s.fault = wb[`CTL_BIT_FAULT];
            nxt_s.enable = wb[`CTL_BIT_ENABLE];
            wr_req = wb[`CTL_BIT_WR] && !s_ff.wr && !s_ff.rd;
            do_read = wb[`CTL_BIT_RD] && !s_ff.wr && !s_ff.rd && !wr_req;
          end
        end
        `OFS_UNLOCK: begin
          nxt_s.key_we = s_ff.wstrb[0];
          nxt_s.key_byte = wb;
        end
        `OFS_ADDR: begin
          m16 = flash_ctrl_pkg::merge16(16'(s_ff.addr), s_ff.wbus, s_ff.wstrb);
          nxt_s.addr = m16[`FLASH_ADDR_W-1:0];
        end
        `OFS_WDATA: begin
          m16 = flash_ctrl_pkg::merge16(16'(s_ff.wdata), s_ff.wbus, s_ff.wstrb);
          nxt_s.wdata = m16[`FLASH_DATA_W-1:0];
        end
        `OFS_RDATA: nxt_s.bresp = `RESP_OKAY;
        `OFS_IRQ_STATUS: begin
          if (s_ff.wstrb[0]) begin
            w1c = wb[`IRQ_W-1:0];
          end
        end
        `OFS_IRQ_MASK: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.mask = wb[`IRQ_W-1:0];
          end
        end
        default: begin
          nxt_s.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (do_read) begin
      nxt_s.rd = 1'b1;
      nxt_s.f_read = 1'b1; // R9
    end
    if (s_ff.rd) begin
      nxt_s.rd = 1'b0; // R9
      nxt_s.rdata = flash_rdata;
      events[`IRQ_BIT_READ] = 1'b1;
    end
    case (s_ff.op)
      flash_ctrl_pkg::OP_IDLE: begin
        if (wr_req) begin
          nxt_s.consume = 1'b1;
          if (!nxt_s.enable || !armed) begin
            nxt_s.fault = 1'b1; // R4 R10
            events[`IRQ_BIT_FAULT] = 1'b1;
          end else begin
            nxt_s.wr = 1'b1; // R6
            nxt_s.fault = 1'b0;
            nxt_s.op_erase = nxt_s.erase_sel;
            if (nxt_s.erase_sel) begin
              nxt_s.f_erase = 1'b1; // R3 R7
              nxt_s.tmr_start = 1'b1;
              nxt_s.tmr_ticks = ERASE_TICKS;
              nxt_s.op = flash_ctrl_pkg::OP_BUSY;
            end else begin
              nxt_s.f_latch = 1'b1; // R2
              if (nxt_s.latch_only) begin
                nxt_s.op = flash_ctrl_pkg::OP_LATCH;
              end else begin
                nxt_s.f_prog = 1'b1; // R2
                nxt_s.tmr_start = 1'b1;
                nxt_s.tmr_ticks = PROG_TICKS;
                nxt_s.op = flash_ctrl_pkg::OP_BUSY;
              end
            end
          end
        end
      end
      flash_ctrl_pkg::OP_LATCH: begin
        nxt_s.wr = 1'b0; // R6
        events[`IRQ_BIT_DONE] = 1'b1;
        nxt_s.op = flash_ctrl_pkg::OP_IDLE;
      end
      flash_ctrl_pkg::OP_BUSY: begin
        if (!nxt_s.enable) begin
          nxt_s.f_abort = 1'b1; // R5
          nxt_s.tmr_abort = 1'b1;
          nxt_s.wr = 1'b0;
          nxt_s.fault = 1'b1; // R4
          events[`IRQ_BIT_FAULT] = 1'b1;
          nxt_s.op = flash_ctrl_pkg::OP_IDLE;
        end else if (tmr_done) begin
          nxt_s.wr = 1'b0; // R6
          if (s_ff.op_erase) begin
            nxt_s.erase_sel = 1'b0; // R3
          end
          events[`IRQ_BIT_DONE] = 1'b1;
          nxt_s.op = flash_ctrl_pkg::OP_IDLE;
        end
      end
      default: begin
        nxt_s.op = flash_ctrl_pkg::OP_IDLE;
      end
    endcase

    // Interrupt: set wins over write-one-to-clear
    nxt_s.status = (s_ff.status & ~w1c) | events;
    nxt_s.irq = |(nxt_s.status & nxt_s.mask);
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = `RESP_OKAY;
      nxt_s.rbus = 32'h00000000;
      case (s_axi_araddr)
        `OFS_CONTROL: nxt_s.rbus[7:0] = {`CTL_TOP_READ, s_ff.space, s_ff.latch_only,
                                        s_ff.erase_sel, s_ff.fault, s_ff.enable,
                                        s_ff.wr, s_ff.rd};
        `OFS_UNLOCK: nxt_s.rbus = 32'h00000000;
        `OFS_ADDR: nxt_s.rbus[`FLASH_ADDR_W-1:0] = s_ff.addr;
        `OFS_RDATA: nxt_s.rbus[`FLASH_DATA_W-1:0] = s_ff.rdata;
        `OFS_WDATA: nxt_s.rbus[`FLASH_DATA_W-1:0] = s_ff.wdata;
        `OFS_IRQ_STATUS: nxt_s.rbus[`IRQ_W-1:0] = s_ff.status;
        `OFS_IRQ_MASK: nxt_s.rbus[`IRQ_W-1:0] = s_ff.mask;
        default: nxt_s.rresp = `RESP_SLVERR;
      endcase
    end
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
    nxt_s.arready = !nxt_s.rvalid;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rresp = s_ff.rresp;
  assign s_axi_rdata = s_ff.rbus;
  assign flash_space = s_ff.space; // R1
  assign flash_addr = s_ff.addr;
  assign flash_wdata = s_ff.wdata;
  assign flash_read = s_ff.f_read;
  assign flash_latch_load = s_ff.f_latch;
  assign flash_row_program = s_ff.f_prog;
  assign flash_erase = s_ff.f_erase;
  assign flash_abort = s_ff.f_abort;
  assign irq = s_ff.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence seq_start_ok;
    s_ff.f_prog || s_ff.f_erase;
  endsequence
  sequence seq_op_end;
    !s_ff.wr && (s_ff.op == flash_ctrl_pkg::OP_IDLE);
  endsequence

  AST_SPACE_FOLLOWS: assert property (flash_read |-> flash_space == $past(nxt_s.space)) // R1
    else $error("space select differs from control bit");
  AST_LATCH_ONLY: assert property ((flash_latch_load && !flash_row_program) |=> !s_ff.wr) // R2
    else $error("latch-only load did not finish in one cycle");
  AST_ERASE_CLEAR: assert property ($fell(s_ff.wr) && s_ff.op_erase && !s_ff.fault // R3
                                    |-> !s_ff.erase_sel)
    else $error("erase select not cleared at erase end");
  AST_FAULT_BAD_START: assert property ((s_ff.consume && !s_ff.wr) |-> s_ff.fault) // R4
    else $error("refused start did not raise fault");
  AST_ENABLE_GATES: assert property (seq_start_ok |-> s_ff.enable) // R5
    else $error("program or erase without enable");
  AST_WR_HW_CLEAR: assert property ($fell(s_ff.wr) |-> s_ff.f_abort // R6
                                    || $past(tmr_done || s_ff.op == flash_ctrl_pkg::OP_LATCH))
    else $error("write command cleared by other than hardware end");
  AST_WR_ENDS: assert property (seq_start_ok |=> tmr_busy ##[1:1000] seq_op_end) // R6
    else $error("self-timed operation did not end in time");
  AST_ERASE_NO_LATCH: assert property (flash_erase |-> !flash_latch_load && !flash_row_program) // R7
    else $error("latch action during erase");
  AST_READ_ONE: assert property ($rose(s_ff.rd) |-> flash_read ##1 (!s_ff.rd && !flash_read)) // R9
    else $error("read command not cleared after one cycle");
  AST_UNLOCK_NEEDED: assert property ((flash_latch_load || flash_erase) |-> $past(armed)) // R10
    else $error("flash modified without unlock");

endmodule : flash_cmd_ctrl

`default_nettype wire

// [logic/flash_ctrl_cfg.svh]
// Constants of the flash command controller: offsets, bit positions,
// bus responses, unlock keys and timing.
// Assumes a 200 MHz system clock and a 32-bit register bus.
`ifndef FLASH_CTRL_CFG_SVH
`define FLASH_CTRL_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_UNLOCK 8'h04
`define OFS_ADDR 8'h08
`define OFS_RDATA 8'h0C
`define OFS_WDATA 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18

// ----------------------------------------------------------------------
// Control and interrupt register fields and widths
// ----------------------------------------------------------------------
`define CTL_BIT_SPACE 6
`define CTL_BIT_LATCH 5
`define CTL_BIT_ERASE 4
`define CTL_BIT_FAULT 3
`define CTL_BIT_ENABLE 2
`define CTL_BIT_WR 1
`define CTL_BIT_RD 0
`define CTL_TOP_READ 1'h1
`define FLASH_ADDR_W 9
`define FLASH_DATA_W 14
`define IRQ_W 3
`define IRQ_BIT_DONE 0
`define IRQ_BIT_FAULT 1
`define IRQ_BIT_READ 2

// ----------------------------------------------------------------------
// Unlock keys, bus answers
// ----------------------------------------------------------------------
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define PROG_TIME_US 2
`define ERASE_TIME_US 2
`define DIV_W 8
`define TICK_W 16

`endif

// [logic/flash_ctrl_pkg.sv]
// Types and a byte-lane merge helper shared by the flash command controller.
// Assumes flash_ctrl_cfg.svh is on the include path.
`include "flash_ctrl_cfg.svh"

package flash_ctrl_pkg;

  typedef enum logic [1:0] {OP_IDLE, OP_LATCH, OP_BUSY} op_state_e;

  typedef struct packed {
    logic [1:0] stage;
  } unlock_s;

  typedef struct packed {
    logic [`DIV_W-1:0] div;
    logic [`TICK_W-1:0] remain;
    logic busy;
    logic done;
  } timer_s;

  typedef struct packed {
    logic space;
    logic latch_only;
    logic erase_sel;
    logic fault;
    logic enable;
    logic wr;
    logic rd;
    op_state_e op;
    logic op_erase;
    logic [`FLASH_ADDR_W-1:0] addr;
    logic [`FLASH_DATA_W-1:0] wdata;
    logic [`FLASH_DATA_W-1:0] rdata;
    logic [`IRQ_W-1:0] status;
    logic [`IRQ_W-1:0] mask;
    logic irq;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wbus;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rbus;
    logic f_read;
    logic f_latch;
    logic f_prog;
    logic f_erase;
    logic f_abort;
    logic key_we;
    logic [7:0] key_byte;
    logic consume;
    logic tmr_start;
    logic tmr_abort;
    logic [`TICK_W-1:0] tmr_ticks;
  } ctrl_s;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] w,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? w[15:8] : old[15:8], strb[0] ? w[7:0] : old[7:0]};
  endfunction : merge16

endpackage : flash_ctrl_pkg

// [logic/flash_unlock_seq.sv]
// Unlock key tracker: two key writes in order arm one program/erase start.
// Assumes key writes arrive as single-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_cfg.svh"

module flash_unlock_seq (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic key_we,
  input wire logic [7:0] key_byte,
  input wire logic consume,
  output logic armed
);

  flash_ctrl_pkg::unlock_s s_ff;
  flash_ctrl_pkg::unlock_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (consume) begin
      nxt_s.stage = 2'h0;
    end else if (key_we) begin
      if (key_byte == `KEY_FIRST) begin
        nxt_s.stage = 2'h1;
      end else if (key_byte == `KEY_SECOND && s_ff.stage == 2'h1) begin
        nxt_s.stage = 2'h2;
      end else begin
        nxt_s.stage = 2'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign armed = (s_ff.stage == 2'h2);

endmodule : flash_unlock_seq

`default_nettype wire

// [logic/flash_op_timer.sv]
// Self-timed operation counter: a divider makes a one-cycle tick enable,
// the operation ends after the requested number of ticks.
// Assumes start and abort are single-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_cfg.svh"

module flash_op_timer #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire logic [`TICK_W-1:0] ticks,
  output logic busy,
  output logic done
);

  localparam logic [`DIV_W-1:0] DIV_LAST = `DIV_W'(TICK_CYCLES - 1);

  flash_ctrl_pkg::timer_s s_ff;
  flash_ctrl_pkg::timer_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (abort) begin
      nxt_s.busy = 1'b0;
    end else if (start) begin
      nxt_s.busy = 1'b1;
      nxt_s.div = '0;
      nxt_s.remain = ticks;
    end else if (s_ff.busy) begin
      if (s_ff.div == DIV_LAST) begin
        nxt_s.div = '0;
        if (s_ff.remain <= `TICK_W'(1)) begin
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
        end else begin
          nxt_s.remain = s_ff.remain - `TICK_W'(1);
        end
      end else begin
        nxt_s.div = s_ff.div + `DIV_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign busy = s_ff.busy;
  assign done = s_ff.done;

endmodule : flash_op_timer

`default_nettype wire

// [verif/flash_cmd_ctrl_tb.sv]
// Self-checking bench for the flash command controller.
// Assumes flash_ctrl_cfg.svh on the include path; the bench drives all ports itself.
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_cfg.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end

module flash_cmd_ctrl_tb;
  logic mclk, rstn;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic space, fread, latch, row, erase, abort, irq;
  logic [`FLASH_ADDR_W-1:0] faddr;
  logic [`FLASH_DATA_W-1:0] fwdata, frdata;
  int bad_count, n_checks, cyc;
  int n_latch, n_row, n_erase, n_abort, n_read;
  logic [31:0] d;
  logic [1:0] r;

  flash_cmd_ctrl #(.PROG_TIME_US(1), .ERASE_TIME_US(1), .TICK_CYCLES(20)) flash_cmd_ctrl_inst (
    .mclk(mclk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_space(space), .flash_addr(faddr), .flash_wdata(fwdata), .flash_read(fread),
    .flash_latch_load(latch), .flash_row_program(row), .flash_erase(erase),
    .flash_abort(abort), .flash_rdata(frdata), .irq(irq)
  );

  // ------------------------------------------------------------------
  // Clock, pulse counters, watchdog
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (latch === 1'b1) n_latch++;
    if (row === 1'b1) n_row++;
    if (erase === 1'b1) n_erase++;
    if (abort === 1'b1) n_abort++;
    if (fread === 1'b1) n_read++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------------
  // Bus master
  // ------------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_write(a, v, r);
    `CHK(r, `RESP_OKAY)
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, d, r);
    `CHK(r, `RESP_OKAY)
    `CHK(d, e)
  endtask : rd_chk

  task automatic unlock();
    wr(`OFS_UNLOCK, 32'h00000055);
    wr(`OFS_UNLOCK, 32'h000000AA);
  endtask : unlock

  task automatic wait_wr_clear();
    int k;
    for (k = 0; k < 100; k++) begin
      axi_read(`OFS_CONTROL, d, r);
      if (d[1] === 1'b0) break;
    end
    `CHK(d[1], 1'b0)
  endtask : wait_wr_clear

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_and_map();
    rd_chk(`OFS_CONTROL, 32'h00000080);
    rd_chk(`OFS_IRQ_STATUS, 32'h00000000);
    rd_chk(`OFS_UNLOCK, 32'h00000000);
    axi_write(8'h1C, 32'hFFFFFFFF, r);
    `CHK(r, `RESP_SLVERR)
    axi_read(8'h1C, d, r);
    `CHK(r, `RESP_SLVERR)
    `CHK(d, 32'h00000000)
  endtask : t_reset_and_map

  task automatic t_fault_starts();
    int l0, p0;
    l0 = n_latch;
    p0 = n_row;
    wr(`OFS_IRQ_MASK, 32'h00000001);
    wr(`OFS_CONTROL, 32'h00000006);
    rd_chk(`OFS_CONTROL, 32'h0000008C);
    `CHK(n_latch - l0, 0)
    `CHK(irq, 1'b0)
    wr(`OFS_IRQ_MASK, 32'h00000002);
    `CHK(irq, 1'b1)
    wr(`OFS_IRQ_STATUS, 32'h00000002);
    `CHK(irq, 1'b0)
    unlock();
    wr(`OFS_CONTROL, 32'h00000002);
    rd_chk(`OFS_CONTROL, 32'h00000088);
    `CHK(n_row - p0, 0)
    `CHK(n_latch - l0, 0)
    wr(`OFS_IRQ_STATUS, 32'h00000002);
  endtask : t_fault_starts

  task automatic t_program();
    int l0, p0, e0;
    l0 = n_latch;
    p0 = n_row;
    e0 = n_erase;
    wr(`OFS_IRQ_MASK, 32'h00000001);
    unlock();
    wr(`OFS_CONTROL, 32'h00000006);
    wr(`OFS_CONTROL, 32'h00000004);
    axi_read(`OFS_CONTROL, d, r);
    `CHK(d[1], 1'b1)
    wait_wr_clear();
    rd_chk(`OFS_CONTROL, 32'h00000084);
    `CHK(n_latch - l0, 1)
    `CHK(n_row - p0, 1)
    `CHK(n_erase - e0, 0)
    `CHK(irq, 1'b1)
    rd_chk(`OFS_IRQ_STATUS, 32'h00000001);
    wr(`OFS_IRQ_STATUS, 32'h00000001);
    `CHK(irq, 1'b0)
  endtask : t_program

  task automatic t_latch_only();
    int l0, p0;
    l0 = n_latch;
    p0 = n_row;
    unlock();
    wr(`OFS_CONTROL, 32'h00000026);
    wait_wr_clear();
    `CHK(n_latch - l0, 1)
    `CHK(n_row - p0, 0)
    wr(`OFS_IRQ_STATUS, 32'h00000007);
  endtask : t_latch_only

  task automatic t_erase();
    int l0, p0, e0;
    l0 = n_latch;
    p0 = n_row;
    e0 = n_erase;
    unlock();
    wr(`OFS_CONTROL, 32'h00000036);
    wait_wr_clear();
    rd_chk(`OFS_CONTROL, 32'h000000A4);
    `CHK(n_erase - e0, 1)
    `CHK(n_latch - l0, 0)
    `CHK(n_row - p0, 0)
    rd_chk(`OFS_IRQ_STATUS, 32'h00000001);
    wr(`OFS_IRQ_STATUS, 32'h00000001);
  endtask : t_erase

  task automatic t_abort();
    int a0;
    a0 = n_abort;
    unlock();
    wr(`OFS_CONTROL, 32'h00000006);
    wr(`OFS_CONTROL, 32'h00000000);
    rd_chk(`OFS_CONTROL, 32'h00000088);
    `CHK(n_abort - a0, 1)
    rd_chk(`OFS_IRQ_STATUS, 32'h00000002);
    wr(`OFS_IRQ_STATUS, 32'h00000002);
  endtask : t_abort

  task automatic t_read();
    int q0;
    q0 = n_read;
    frdata <= 14'h2A5C;
    wr(`OFS_ADDR, 32'h000001A5);
    wr(`OFS_CONTROL, 32'h00000041);
    `CHK(space, 1'b1)
    `CHK(faddr, 9'h1A5)
    rd_chk(`OFS_CONTROL, 32'h000000C0);
    `CHK(n_read - q0, 1)
    wr(`OFS_WDATA, 32'h00003ABC);
    `CHK(fwdata, 14'h3ABC)
    rd_chk(`OFS_WDATA, 32'h00003ABC);
    rd_chk(`OFS_RDATA, 32'h00002A5C);
    rd_chk(`OFS_IRQ_STATUS, 32'h00000004);
    wr(`OFS_IRQ_STATUS, 32'h00000004);
    wr(`OFS_CONTROL, 32'h00000000);
    `CHK(space, 1'b0)
  endtask : t_read

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    frdata = '0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_reset_and_map();
    t_fault_starts();
    t_program();
    t_latch_only();
    t_erase();
    t_abort();
    t_read();
    report_and_stop();
  end
endmodule : flash_cmd_ctrl_tb

`default_nettype wire
